// ==== shared/fwp_pkg.sv ====
// Package: constants and carrier types for the flash write-protect checker
package fwp_pkg;

  // ****************************************
  // Array geometry
  // ****************************************
  localparam int ADDR_W = 21;                       // 2 MB array
  localparam logic [20:0] ADDR_TOP = 21'h1F_FFFF;   // Last byte address
  localparam int BLK64_SHIFT = 16;                  // 64 KB step
  localparam int SEC4_SHIFT = 12;                   // 4 KB step
  localparam int NUM_LOCKS = 48;                    // 32 blocks + 16 sectors
  localparam logic [47:0] LOCK_RESET = 48'hFFFF_FFFF_FFFF; // All locked

  // ****************************************
  // Reset values and timing
  // ****************************************
  localparam logic [7:0] STATUS_RESET = 8'h00;      // Delivery status value
  localparam logic [7:0] ERASED_BYTE = 8'hFF;       // Delivery array value
  localparam int CLK_HZ = 10_000_000;               // mclk rate
  localparam int POWER_TO_SELECT_US = 70;           // Least delay, us
  localparam int POWER_TO_SELECT_CYC =
    (POWER_TO_SELECT_US * (CLK_HZ / 1_000_000));    // 700 cycles
  localparam logic [2:0] BYTE_LAST_BIT = 3'h7;      // Index of the last bit in a byte

  // Command classes seen by the checker
  typedef enum logic [2:0] {
    FWP_CMD_NONE = 3'h0,   // Nothing / read type
    FWP_CMD_SET_WRITE_LATCH = 3'h1,   // Set write latch
    FWP_CMD_CLEAR_WRITE_LATCH = 3'h2, // Clear write latch
    FWP_CMD_PROG = 3'h3,              // Program or erase over a span
    FWP_CMD_STATUS_WRITE = 3'h4,      // Status register write
    FWP_CMD_SLEEP = 3'h5,             // Enter deep power-down
    FWP_CMD_WAKE = 3'h6               // Release from deep power-down
  } fwp_cmd_type;

  // Checker states, Gray coded along standby-active-verdict
  typedef enum logic [1:0] {
    FWP_ST_STANDBY = 2'b00,
    FWP_ST_ACTIVE = 2'b01,
    FWP_ST_VERDICT = 2'b11
  } fwp_state_type;

  // Protection configuration bits
  typedef struct packed {
    logic prot_granule_select;   // 4 KB granule when set
    logic prot_end_select;       // Bottom when set
    logic [2:0] prot_field;      // Low field bits
    logic prot_invert;           // Complement
    logic per_block_lock_select; // Individual locks
    logic status_lock_b0;
    logic status_lock_b1;
  } fwp_prot_type;

  // A command presented at chip-select rise
  typedef struct packed {
    fwp_cmd_type cmd;
    logic [20:0] start_addr;
    logic [20:0] end_addr;
    logic [7:0] status_data;    // Value for a status write
  } fwp_req_type;

  // Decision handed to the array side
  typedef struct packed {
    logic grant;                // Command may run
    logic refuse;               // Command discarded
  } fwp_verdict_type;
endpackage

// ==== src/fwp_check.sv ====
// Module: write-protect checker in front of the flash array

module fwp_check
  import fwp_pkg::*;
(
  input wire logic mclk,               // 10 MHz clock
  input wire logic reset_n,            // Power-on reset, active low
  input wire logic clk_en,             // Freezes all state when low
  input wire logic sel_n,              // Chip select, active low
  input wire logic [2:0] bit_count,    // Bits into current byte
  input wire fwp_req_type req,         // Decoded command at rise
  input wire logic wp_n,               // Write-protect pin, active low
  input wire logic lock_we,            // Write one individual lock
  input wire logic [5:0] lock_idx,     // Lock index, sectors after 32
  input wire logic lock_val,           // Lock value
  output fwp_verdict_type verdict,     // One-cycle grant or refuse
  output logic [7:0] status,           // Status register image
  output logic write_enable_latch,     // Latch state
  output logic deep_down,              // In deep power-down
  output logic select_ready            // Power-to-select delay elapsed
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    fwp_state_type st;       // Command tracking state
    logic sel_q;             // Previous select level
    fwp_prot_type prot;      // Protection bits
    logic wr_latch;          // Write latch
    logic dpd;               // Deep power-down
    logic [47:0] locks;      // Individual lock bits
    logic [9:0] pwr_cnt;     // Power-to-select counter
    logic rdy;               // Counter done
    fwp_verdict_type vd;     // Verdict output
  } fwp_state_all_type;

  fwp_state_all_type s, next_s;

  // Span overlap test; both ends inclusive
  function automatic logic overlaps(input logic [20:0] a0,
      input logic [20:0] a1, input logic [20:0] p0,
      input logic [20:0] p1);
    overlaps = (a0 <= p1) && (p0 <= a1);
  endfunction

  // Decode the field into a range; empty flag for nothing
  logic [20:0] lo, hi, sz;
  logic none_f, all_f, hit;
  always_comb begin
    fwp_prot_type p;
    logic [2:0] f;
    p = s.prot;
    f = p.prot_field;
    sz = '0;
    none_f = (f == 3'h0);
    all_f = (f[2:1] == 2'b11);
    if (p.prot_granule_select) begin
      // 4 KB .. 32 KB; 10x and 101 both give 32 KB
      sz = (f[2] ? 21'h00_8000 : (21'h00_1000 << (f[1:0] - 2'd1)));
    end else begin
      // 64 KB .. 1 MB
      sz = 21'h01_0000 << (f - 3'd1);
    end
    if (p.prot_end_select) begin
      lo = '0;                                 // Bottom end
      hi = sz - 21'h00_0001;
    end else begin
      lo = 21'(ADDR_TOP - sz + 21'h00_0001);  // Top end
      hi = ADDR_TOP;
    end
    if (all_f) begin
      lo = '0;
      hi = ADDR_TOP;
    end
    // Full span of the command is tested
    hit = !none_f && overlaps(req.start_addr, req.end_addr, lo, hi);
    if (p.prot_invert) begin
      // Complement: protected iff span leaves the plain range
      hit = none_f || !((req.start_addr >= lo) && (req.end_addr <= hi))
        || all_f ? (none_f || !all_f &&
        !((req.start_addr >= lo) && (req.end_addr <= hi))) : 1'b0;
    end
  end

  // Individual lock check over the span
  logic lock_hit;
  always_comb begin
    lock_hit = 1'b0;
    for (int i = 0; i < 32; i++) begin
      if (s.locks[i] && overlaps(req.start_addr, req.end_addr,
          21'(i << BLK64_SHIFT), 21'(((i + 1) << BLK64_SHIFT) - 1)))
        lock_hit = 1'b1;
    end
    // Sector locks 32..47 cover the sixteen sectors of block 0 only
    for (int j = 0; j < 16; j++) begin
      if (s.locks[32 + j] && overlaps(req.start_addr, req.end_addr,
          21'(j << SEC4_SHIFT), 21'(((j + 1) << SEC4_SHIFT) - 1)))
        lock_hit = 1'b1;
    end
  end

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    logic rise, full_byte, prot_area;
    rise = sel_n && !s.sel_q;
    full_byte = (bit_count == 3'h0);
    // Lock bits or field decode, never both
    prot_area = s.prot.per_block_lock_select ? lock_hit : hit;
    next_s = s;
    next_s.sel_q = sel_n;
    next_s.vd = '0;
    if (!s.rdy) begin
      next_s.pwr_cnt = 10'(s.pwr_cnt + 10'd1);
      if (s.pwr_cnt == 10'(POWER_TO_SELECT_CYC - 1))
        next_s.rdy = 1'b1;
    end
    // Indexes past the last sector lock are dropped, not wrapped
    if (lock_we && !s.dpd && (lock_idx < 6'(NUM_LOCKS)))
      next_s.locks[lock_idx] = lock_val;
    case (s.st)
      FWP_ST_STANDBY: begin
        if (!sel_n && s.sel_q)
          next_s.st = FWP_ST_ACTIVE;
      end
      FWP_ST_ACTIVE: begin
        if (rise) begin
          next_s.st = FWP_ST_VERDICT;
          next_s.vd.refuse = 1'b1;             // Default
          if (req.cmd == FWP_CMD_NONE) begin
            next_s.vd.refuse = 1'b0;
          end else if (!full_byte) begin
            // Partial byte: discard
          end else if (s.dpd) begin
            if (req.cmd == FWP_CMD_WAKE) begin
              next_s.dpd = 1'b0;
              next_s.vd = '{grant: 1'b1, refuse: 1'b0};
            end
          end else begin
            case (req.cmd)
              FWP_CMD_SET_WRITE_LATCH: begin
                next_s.wr_latch = 1'b1;
                next_s.vd = '{grant: 1'b1, refuse: 1'b0};
              end
              FWP_CMD_CLEAR_WRITE_LATCH: begin
                next_s.wr_latch = 1'b0;
                next_s.vd = '{grant: 1'b1, refuse: 1'b0};
              end
              FWP_CMD_SLEEP: begin
                next_s.dpd = 1'b1;
                next_s.vd = '{grant: 1'b1, refuse: 1'b0};
              end
              FWP_CMD_PROG: begin
                if (s.wr_latch && !prot_area) begin
                  next_s.vd = '{grant: 1'b1, refuse: 1'b0};
                end
                next_s.wr_latch = 1'b0;
              end
              FWP_CMD_STATUS_WRITE: begin
                if (s.wr_latch) begin
                  next_s.vd = '{grant: 1'b1, refuse: 1'b0};
                  next_s.prot.per_block_lock_select = req.status_data[7];
                  if (wp_n) begin
                    next_s.prot.prot_field = req.status_data[2:0];
                    next_s.prot.prot_end_select = req.status_data[3];
                    next_s.prot.prot_granule_select = req.status_data[4];
                    next_s.prot.prot_invert = req.status_data[5];
                    next_s.prot.status_lock_b0 = req.status_data[6];
                  end
                end
                next_s.wr_latch = 1'b0;
              end
              default: begin
                next_s.vd.refuse = 1'b1;
              end
            endcase
          end
        end
      end
      FWP_ST_VERDICT: begin
        next_s.st = FWP_ST_STANDBY;
      end
      default: begin
        next_s.st = FWP_ST_STANDBY;
      end
    endcase
  end

  // ****************************************
  // Registers
  // ****************************************
  // Power-on values: standby, status zero, every lock set
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      s.st <= FWP_ST_STANDBY;
      s.sel_q <= 1'b1;
      // Same bit order as the status image
      {s.prot.per_block_lock_select, s.prot.status_lock_b0,
        s.prot.prot_invert, s.prot.prot_granule_select,
        s.prot.prot_end_select, s.prot.prot_field} <= STATUS_RESET;
      s.prot.status_lock_b1 <= 1'b0;
      s.wr_latch <= 1'b0;
      s.dpd <= 1'b0;
      s.locks <= LOCK_RESET;
      s.pwr_cnt <= '0;
      s.rdy <= 1'b0;
      s.vd <= '0;
    end else if (clk_en) begin
      s <= next_s;
    end
  end

  assign verdict = s.vd;
  assign write_enable_latch = s.wr_latch;
  assign deep_down = s.dpd;
  assign select_ready = s.rdy;
  assign status = {s.prot.per_block_lock_select, s.prot.status_lock_b0,
    s.prot.prot_invert, s.prot.prot_granule_select,
    s.prot.prot_end_select, s.prot.prot_field};

  // ****************************************
  // Checks
  // ****************************************
  sequence sel_rise_s;
    !s.sel_q && sel_n && s.st == FWP_ST_ACTIVE && clk_en;
  endsequence

  no_latch_grant_a: assert property (@(posedge mclk) disable iff (!reset_n)
    sel_rise_s and (req.cmd == FWP_CMD_PROG) and !s.wr_latch
    |=> !verdict.grant) else $error("program granted without latch");
  partial_byte_a: assert property (@(posedge mclk) disable iff (!reset_n)
    sel_rise_s and (bit_count != 3'h0) and (req.cmd != FWP_CMD_NONE)
    |=> verdict.refuse) else $error("partial byte not refused");
  dpd_block_a: assert property (@(posedge mclk) disable iff (!reset_n)
    sel_rise_s and s.dpd and (req.cmd != FWP_CMD_WAKE)
    |=> !verdict.grant) else $error("command in deep power-down");
  prot_hit_a: assert property (@(posedge mclk) disable iff (!reset_n)
    sel_rise_s and (req.cmd == FWP_CMD_PROG) and !s.prot.per_block_lock_select
    and hit |=> !verdict.grant) else $error("protected span granted");
  wp_freeze_a: assert property (@(posedge mclk) disable iff (!reset_n)
    !wp_n && clk_en |=> status[6:0] == $past(status[6:0]))
    else $error("protect bits changed with pin low");
  ready_time_a: assert property (@(posedge mclk) disable iff (!reset_n)
    $rose(select_ready) |-> s.pwr_cnt == 10'(POWER_TO_SELECT_CYC))
    else $error("select delay wrong");
  verdict_pulse_a: assert property (@(posedge mclk) disable iff (!reset_n)
    verdict.grant && clk_en |=> !verdict.grant)
    else $error("verdict longer than one cycle");
  lock_mode_a: assert property (@(posedge mclk) disable iff (!reset_n)
    sel_rise_s and (req.cmd == FWP_CMD_PROG) and s.prot.per_block_lock_select
    and lock_hit |=> !verdict.grant) else $error("locked span granted");
endmodule

// ==== tb/fwp_host.sv ====
// Host controller model that frames commands with chip select
module fwp_host
  import fwp_pkg::*;
(
  input wire logic mclk, // 10 MHz clock
  input wire fwp_verdict_type verdict, // Checker decision
  input wire logic select_ready, // Power-to-select delay over
  output logic sel_n, // Chip select, active low
  output logic [2:0] bit_count, // Bits into last byte at rise
  output fwp_req_type req // Command presented at rise
);
  timeunit 1ns;
  timeprecision 1ps;

  // ********************
  // Idle levels
  // ********************
  initial begin
    sel_n = 1'b1;
    bit_count = 3'h0;
    req = '0;
  end

  // Frames one command and returns any verdict pulse seen
  task automatic run(input fwp_cmd_type c, input logic [20:0] sa, ea,
                     input logic [7:0] sd, input logic [2:0] bc,
                     output fwp_verdict_type v);
    int i;
    v = '0;
    i = 0;
    // Wait up to 1000 cycles for the power-to-select delay before selecting
    while (select_ready !== 1'b1 && i < 1000) begin
      @(posedge mclk);
      i++;
    end
    @(posedge mclk);
    sel_n <= 1'b0;
    repeat (3) @(posedge mclk);
    sel_n <= 1'b1;
    bit_count <= bc;
    req <= '{c, sa, ea, sd};
    for (i = 0; i < 4; i++) begin
      @(posedge mclk);
      #1;
      if (verdict.grant || verdict.refuse) begin
        v = verdict;
      end
    end
    // Released lines toggle so stale values are never mistaken for live
    @(posedge mclk);
    req <= ~req;
    bit_count <= ~bit_count;
  endtask
endmodule

// ==== tb/tb_flash_write_protect_check.sv ====
// Self-checking bench for the flash write-protect checker
module tb_flash_write_protect_check
  import fwp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ********************
  // Signals
  // ********************
  localparam fwp_verdict_type GRANT = 2'b10; // Grant only
  localparam fwp_verdict_type REFUSE = 2'b01; // Refuse only
  localparam fwp_verdict_type NO_VERDICT = 2'b00; // No pulse at all
  logic mclk, reset_n, clk_en, sel_n, wp_n, lock_we, lock_val;
  logic write_enable_latch, deep_down, select_ready;
  logic [2:0] bit_count;
  logic [5:0] lock_idx;
  logic [7:0] status;
  fwp_req_type req;
  fwp_verdict_type verdict;
  int n_errors = 0;
  int n_checks = 0;
  // Region table: status value, two 4 KB spans and their verdicts
  logic [7:0] sd_t [7] = '{8'h01, 8'h11, 8'h09, 8'h21, 8'h06, 8'h20, 8'h26};
  logic [20:0] a_t [7] = '{21'h1E_F000, 21'h1F_E000, 21'h01_0000,
    21'h1F_0000, 21'h00_0000, 21'h00_0000, 21'h00_0000};
  logic [20:0] b_t [7] = '{21'h1E_F800, 21'h1F_E800, 21'h00_F800,
    21'h1E_F800, 21'h1F_F000, 21'h1F_F000, 21'h1F_F000};
  logic [0:6] ga = 7'b1111001; // Grant expected for first span
  logic [0:6] gb = 7'b0000001; // Grant expected for second span

  fwp_check i_dut (.mclk, .reset_n, .clk_en, .sel_n, .bit_count,
    .req, .wp_n, .lock_we, .lock_idx, .lock_val, .verdict, .status,
    .write_enable_latch, .deep_down, .select_ready);
  fwp_host i_host (.mclk, .verdict, .select_ready, .sel_n, .bit_count,
    .req);

  // Clock of 100 ns period
  initial mclk = 1'b0;
  always #50 mclk = ~mclk;

  // ********************
  // Shared tasks
  // ********************
  task automatic check(input logic [31:0] s, e, input string m);
    n_checks++;
    if (s !== e) begin
      n_errors++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask

  // One command over a 4 KB span, verdict compared
  task automatic op(input fwp_cmd_type c, input logic [20:0] a,
                    input logic [7:0] d, input logic [2:0] bc,
                    input fwp_verdict_type e);
    fwp_verdict_type v;
    i_host.run(c, a, a + 21'hFFF, d, bc, v);
    check(v, e, "verdict");
  endtask

  // Latch set first, then the command
  task automatic wop(input fwp_cmd_type c, input logic [20:0] a,
                     input logic [7:0] d, input fwp_verdict_type e);
    op(FWP_CMD_SET_WRITE_LATCH, 21'h0, 8'h00, 3'h0, GRANT);
    op(c, a, d, 3'h0, e);
  endtask

  task automatic stop_test;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ********************
  // Scenarios
  // ********************
  task automatic t_reset;
    check(status, 8'h00, "status");
    check({write_enable_latch, deep_down}, 2'b00, "levels");
    repeat (POWER_TO_SELECT_CYC + 5) @(posedge mclk);
    check(select_ready, 1'b1, "ready");
    $display("t_reset done");
  endtask

  task automatic t_latch;
    op(FWP_CMD_PROG, 21'h0, 8'h00, 3'h0, REFUSE);
    wop(FWP_CMD_PROG, 21'h0, 8'h00, GRANT);
    check(write_enable_latch, 1'b0, "latch");
    op(FWP_CMD_SET_WRITE_LATCH, 21'h0, 8'h00, 3'h3, REFUSE);
    check(write_enable_latch, 1'b0, "latch");
    $display("t_latch done");
  endtask

  // A frame sent while the enable is low must leave no trace
  task automatic t_freeze;
    clk_en <= 1'b0;
    op(FWP_CMD_SET_WRITE_LATCH, 21'h0, 8'h00, 3'h0, NO_VERDICT);
    check(write_enable_latch, 1'b0, "frozen latch");
    clk_en <= 1'b1;
    $display("t_freeze done");
  endtask

  // Spans that straddle a boundary by 2 KB must still be refused
  task automatic t_region;
    for (int i = 0; i < 7; i++) begin
      wop(FWP_CMD_STATUS_WRITE, 21'h0, sd_t[i], GRANT);
      check(status, sd_t[i], "status");
      wop(FWP_CMD_PROG, a_t[i], 8'h00, ga[i] ? GRANT : REFUSE);
      wop(FWP_CMD_PROG, b_t[i], 8'h00, gb[i] ? GRANT : REFUSE);
    end
    $display("t_region done");
  endtask

  task automatic t_wp;
    wp_n <= 1'b0;
    wop(FWP_CMD_STATUS_WRITE, 21'h0, 8'h05, GRANT);
    check(status, 8'h26, "status frozen");
    wp_n <= 1'b1;
    $display("t_wp done");
  endtask

  task automatic t_dpd;
    op(FWP_CMD_SLEEP, 21'h0, 8'h00, 3'h0, GRANT);
    check(deep_down, 1'b1, "down");
    op(FWP_CMD_SET_WRITE_LATCH, 21'h0, 8'h00, 3'h0, REFUSE);
    op(FWP_CMD_WAKE, 21'h0, 8'h00, 3'h0, GRANT);
    check(deep_down, 1'b0, "down");
    $display("t_dpd done");
  endtask

  // Clears one individual lock with a single-cycle write pulse
  task automatic lock_write(input logic [5:0] idx);
    @(posedge mclk);
    lock_idx <= idx;
    lock_we <= 1'b1;
    @(posedge mclk);
    lock_we <= 1'b0;
  endtask

  // Block lock and sector lock both guard address zero
  task automatic t_locks;
    wop(FWP_CMD_STATUS_WRITE, 21'h0, 8'h80, GRANT);
    wop(FWP_CMD_PROG, 21'h05_0000, 8'h00, REFUSE);
    lock_write(6'h05);
    wop(FWP_CMD_PROG, 21'h05_0000, 8'h00, GRANT);
    lock_write(6'h00);
    wop(FWP_CMD_PROG, 21'h00_0000, 8'h00, REFUSE);
    lock_write(6'h20);
    wop(FWP_CMD_PROG, 21'h00_0000, 8'h00, GRANT);
    wop(FWP_CMD_STATUS_WRITE, 21'h0, 8'h00, GRANT);
    wop(FWP_CMD_PROG, 21'h06_0000, 8'h00, GRANT);
    $display("t_locks done");
  endtask

  // ********************
  // Main sequence and watchdog
  // ********************
  initial begin
    reset_n = 1'b0;
    wp_n = 1'b1;
    lock_we = 1'b0;
    lock_idx = 6'h00;
    lock_val = 1'b0;
    clk_en = 1'b1;
    repeat (4) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    #1;
    t_reset();
    t_latch();
    t_freeze();
    t_region();
    t_wp();
    t_dpd();
    t_locks();
    stop_test();
  end

  // Roughly twenty times the expected run length
  initial begin
    #3_000_000;
    n_errors++;
    stop_test();
  end
endmodule
